// [hw/ctp_port.v]
// serial target port and register set of the clock synthesizer
`timescale 1ns/1ns
`include "ctp_defines.vh"
module ctp_port
(
	input wire clock,
	input wire rst,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out_r,
	output reg sda_oe_r,
	input wire addr_select_pin,
	input wire pll_lock,
	output reg [7:0] input_ctl_r,
	output reg [7:0] loop_work_r,
	output reg [11:0] fbd_work_r,
	output reg [7:0] dpa_offset_r,
	output reg [1:0] dpa_res_work_r,
	output reg [7:0] out_en_r,
	output reg [7:0] osc_div_r,
	output reg pll_reset_r,
	output reg phase_adjuster_reset_r
);
	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam ST_IDLE = 3'd0;
	localparam ST_ADDR = 3'd1;
	localparam ST_AACK = 3'd2;
	localparam ST_WBYTE = 3'd3;
	localparam ST_WACK = 3'd4;
	localparam ST_RBYTE = 3'd5;
	localparam ST_RACK = 3'd6;
	// full-width copies of header constants, so that only the implemented bits are taken
	localparam [7:0] RST_FBD1 = `CTP_RST_FBD1;
	localparam [7:0] RST_DPACTL = `CTP_RST_DPACTL;
	localparam [7:0] MASK_DPACTL = `CTP_MASK_DPACTL;

	wire scl_s; // synchronised clock line
	wire sda_s; // synchronised data line
	wire sel_s; // synchronised address select
	reg scl_d_r; // previous clock line
	reg sda_d_r; // previous data line
	reg [2:0] state_r;
	reg [2:0] bitcnt_r; // bits left minus one
	reg [7:0] shift_r; // receive/transmit shifter
	reg [7:0] index_r; // register index
	reg have_idx_r; // index byte received this write
	reg rw_r; // current direction, 1 = read
	reg [7:0] loop_sh_r; // shadow loop control
	reg [7:0] fbd0_sh_r; // shadow feedback divider low
	reg [7:0] fbd1_sh_r; // shadow feedback divider high
	reg [1:0] dpa_sh_r; // shadow resolution
	reg [7:0] rdata; // read mux

	ctp_sync u_scl (.clock(clock), .rst(rst), .din(scl_in), .dout_r(scl_s));
	ctp_sync u_sda (.clock(clock), .rst(rst), .din(sda_in), .dout_r(sda_s));
	ctp_sync u_sel (.clock(clock), .rst(rst), .din(addr_select_pin), .dout_r(sel_s));

	// line events seen on the synchronised copies
	wire scl_rise = scl_s & ~scl_d_r;
	wire scl_fall = ~scl_s & scl_d_r;
	wire start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
	wire stop_ev = scl_s & scl_d_r & ~sda_d_r & sda_s;
	// next index: upper nibble held, low nibble wraps
	wire [7:0] index_inc = {index_r[7:4], index_r[3:0] + 4'h1};

	// ----------------------------------------
	// read data selection
	// ----------------------------------------
	always @*
	begin
		rdata = 8'h00;
		if (index_r == `CTP_IDX_INCTL)
			rdata = input_ctl_r;
		else if (index_r == `CTP_IDX_LOOP)
			rdata = loop_sh_r;
		else if (index_r == `CTP_IDX_FBD0)
			rdata = fbd0_sh_r;
		else if (index_r == `CTP_IDX_FBD1)
			rdata = fbd1_sh_r;
		else if (index_r == `CTP_IDX_DPAOS)
			rdata = dpa_offset_r;
		else if (index_r == `CTP_IDX_DPACTL)
			rdata = {6'h00, dpa_sh_r};
		else if (index_r == `CTP_IDX_OE)
			rdata = out_en_r;
		else if (index_r == `CTP_IDX_OSC)
			rdata = osc_div_r;
		else if (index_r == `CTP_IDX_VER)
			rdata = `CTP_CHIP_VER; // arbitrary identity value
		else if (index_r == `CTP_IDX_REV)
			rdata = `CTP_CHIP_REV;
		else if (index_r == `CTP_IDX_STAT)
			rdata = {6'h00, pll_lock, 1'b0};
	end

	// ----------------------------------------
	// protocol engine and register writes
	// ----------------------------------------
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			state_r <= ST_IDLE;
			bitcnt_r <= 3'd7;
			shift_r <= 8'h00;
			index_r <= 8'h00;
			have_idx_r <= 1'b0;
			rw_r <= 1'b0;
			sda_out_r <= 1'b1;
			sda_oe_r <= 1'b0;
			input_ctl_r <= `CTP_RST_INCTL;
			loop_sh_r <= `CTP_RST_LOOP;
			fbd0_sh_r <= `CTP_RST_FBD0;
			fbd1_sh_r <= `CTP_RST_FBD1;
			dpa_offset_r <= `CTP_RST_DPAOS;
			dpa_sh_r <= RST_DPACTL[1:0];
			out_en_r <= `CTP_RST_OE;
			osc_div_r <= `CTP_RST_OSC;
			loop_work_r <= `CTP_RST_LOOP;
			fbd_work_r <= {RST_FBD1[3:0], `CTP_RST_FBD0};
			dpa_res_work_r <= RST_DPACTL[1:0];
			pll_reset_r <= 1'b0;
			phase_adjuster_reset_r <= 1'b0;
		end
		else
		begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
			pll_reset_r <= 1'b0;
			phase_adjuster_reset_r <= 1'b0;
			if (start_ev)
			begin
				// start or repeated start: expect an address
				state_r <= ST_ADDR;
				bitcnt_r <= 3'd7;
				have_idx_r <= 1'b0;
				sda_oe_r <= 1'b0;
			end
			else if (stop_ev)
			begin
				state_r <= ST_IDLE;
				sda_oe_r <= 1'b0;
			end
			else
			begin
				case (state_r)
				ST_ADDR, ST_WBYTE:
				begin
					if (scl_rise)
					begin
						shift_r <= {shift_r[6:0], sda_s};
						if (bitcnt_r == 3'd0)
							state_r <= (state_r == ST_ADDR) ? ST_AACK : ST_WACK;
						else
							bitcnt_r <= bitcnt_r - 3'd1;
					end
				end
				ST_AACK:
				begin
					if (scl_fall && !sda_oe_r)
					begin
						// compare address, select bit from pin
						if (shift_r[7:1] == {`CTP_ADDR_HI, sel_s})
						begin
							rw_r <= shift_r[0];
							sda_out_r <= 1'b0;
							sda_oe_r <= 1'b1;
						end
						else
							state_r <= ST_IDLE;
					end
					else if (scl_fall)
					begin
						// acknowledge slot done
						bitcnt_r <= 3'd7;
						if (rw_r)
						begin
							state_r <= ST_RBYTE;
							shift_r <= {rdata[6:0], 1'b0};
							sda_out_r <= rdata[7];
							sda_oe_r <= ~rdata[7];
						end
						else
						begin
							state_r <= ST_WBYTE;
							sda_oe_r <= 1'b0;
						end
					end
				end
				ST_WACK:
				begin
					if (scl_fall && !sda_oe_r)
					begin
						sda_out_r <= 1'b0;
						sda_oe_r <= 1'b1;
						if (!have_idx_r)
						begin
							index_r <= shift_r; // only path to upper nibble
							have_idx_r <= 1'b1;
						end
						else
						begin
							if (index_r == `CTP_IDX_INCTL)
								input_ctl_r <= shift_r;
							else if (index_r == `CTP_IDX_LOOP)
								loop_sh_r <= shift_r & `CTP_MASK_LOOP;
							else if (index_r == `CTP_IDX_FBD0)
								fbd0_sh_r <= shift_r;
							else if (index_r == `CTP_IDX_FBD1)
								fbd1_sh_r <= shift_r & `CTP_MASK_FBD1;
							else if (index_r == `CTP_IDX_DPAOS)
								dpa_offset_r <= shift_r & `CTP_MASK_DPAOS;
							else if (index_r == `CTP_IDX_DPACTL)
								dpa_sh_r <= shift_r[1:0] & MASK_DPACTL[1:0];
							else if (index_r == `CTP_IDX_OE)
								out_en_r <= shift_r;
							else if (index_r == `CTP_IDX_OSC)
								osc_div_r <= shift_r;
							else if (index_r == `CTP_IDX_RESET)
							begin
								if (shift_r[7:4] == `CTP_PLL_CODE)
								begin
									// pll reset loads working copies
									pll_reset_r <= 1'b1;
									loop_work_r <= loop_sh_r;
									fbd_work_r <= {fbd1_sh_r[3:0], fbd0_sh_r};
								end
								if (shift_r[3:0] == `CTP_DPA_CODE)
								begin
									phase_adjuster_reset_r <= 1'b1;
									dpa_res_work_r <= dpa_sh_r;
								end
							end
							index_r <= index_inc;
						end
					end
					else if (scl_fall)
					begin
						state_r <= ST_WBYTE;
						bitcnt_r <= 3'd7;
						sda_oe_r <= 1'b0;
					end
				end
				ST_RBYTE:
				begin
					if (scl_fall)
					begin
						if (bitcnt_r == 3'd0)
						begin
							// release for master acknowledge
							state_r <= ST_RACK;
							sda_oe_r <= 1'b0;
							sda_out_r <= 1'b1;
							index_r <= index_inc;
						end
						else
						begin
							bitcnt_r <= bitcnt_r - 3'd1;
							sda_out_r <= shift_r[7];
							sda_oe_r <= ~shift_r[7];
							shift_r <= {shift_r[6:0], 1'b0};
						end
					end
				end
				ST_RACK:
				begin
					if (scl_rise)
					begin
						if (sda_s)
							state_r <= ST_IDLE; // no acknowledge ends read
						else
							bitcnt_r <= 3'd7; // master wants another byte
					end
					else if (scl_fall && bitcnt_r == 3'd7)
					begin
						// next byte, index already advanced; master owns this ack, so no address compare
						state_r <= ST_RBYTE;
						shift_r <= {rdata[6:0], 1'b0};
						sda_out_r <= rdata[7];
						sda_oe_r <= ~rdata[7];
					end
				end
				default:
					state_r <= ST_IDLE;
				endcase
			end
		end
	end
endmodule // ctp_port

// [hw/ctp_defines.vh]
// constants for the serial configuration port of the clock synthesizer
// Behaviour
// - address is 010011 plus select pin level
// - single write: address, index, data, all acknowledged
// - single read: index write, restart, one byte
// - all bytes shifted most significant bit first
// - acknowledge is low, no acknowledge high
// - multi write: many data bytes until stop
// - multi read: master acks all but last
// - low index nibble increments after each data byte
// - upper index nibble never changes by increment
// - select low: 4Ch/4Dh, high: 4Eh/4Fh
// - upper nibble 5 resets pll, loads working copies from shadows
// - lower nibble A resets phase adjuster, loads
`ifndef CTP_DEFINES_VH
`define CTP_DEFINES_VH
// ----------------------------------------
// target address
// ----------------------------------------
`define CTP_ADDR_HI 6'h13
// ----------------------------------------
// register indices
// ----------------------------------------
`define CTP_IDX_INCTL 8'h00
`define CTP_IDX_LOOP 8'h01
`define CTP_IDX_FBD0 8'h02
`define CTP_IDX_FBD1 8'h03
`define CTP_IDX_DPAOS 8'h04
`define CTP_IDX_DPACTL 8'h05
`define CTP_IDX_OE 8'h06
`define CTP_IDX_OSC 8'h07
`define CTP_IDX_RESET 8'h08
`define CTP_IDX_VER 8'h10
`define CTP_IDX_REV 8'h11
`define CTP_IDX_STAT 8'h12
// ----------------------------------------
// reset values
// ----------------------------------------
`define CTP_RST_INCTL 8'h41
`define CTP_RST_LOOP 8'h00
`define CTP_RST_FBD0 8'hff
`define CTP_RST_FBD1 8'h0f
`define CTP_RST_DPAOS 8'h00
`define CTP_RST_DPACTL 8'h03
`define CTP_RST_OE 8'h00
`define CTP_RST_OSC 8'h80
// ----------------------------------------
// soft reset codes and identity
// ----------------------------------------
`define CTP_PLL_CODE 4'h5
`define CTP_DPA_CODE 4'ha
`define CTP_CHIP_VER 8'h5a
`define CTP_CHIP_REV 8'h01
// mask of implemented bits for writable indices 01, 03, 04 and 05
`define CTP_MASK_LOOP 8'h37
`define CTP_MASK_FBD1 8'h0f
`define CTP_MASK_DPAOS 8'hbf
`define CTP_MASK_DPACTL 8'h03
`endif

// [hw/ctp_sync.v]
// two-flop synchroniser for one pin input
`timescale 1ns/1ns
module ctp_sync
(
	input wire clock,
	input wire rst,
	input wire din,
	output reg dout_r
);
	// first stage, read only by the second
	reg meta_r;

	// ----------------------------------------
	// two-stage sampling, idle high
	// ----------------------------------------
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			meta_r <= 1'b1;
			dout_r <= 1'b1;
		end
		else
		begin
			meta_r <= din;
			dout_r <= meta_r;
		end
	end
endmodule // ctp_sync

// [bench/ctp_port_properties.sv]
// concurrent checks on the serial port pins and the soft reset pulses
`timescale 1ns/1ns
module ctp_port_properties
(
	input wire clock,
	input wire rst,
	input wire scl_in,
	input wire sda_oe_r,
	input wire sda_out_r,
	input wire [7:0] loop_work_r,
	input wire [11:0] fbd_work_r,
	input wire [1:0] dpa_res_work_r,
	input wire pll_reset_r,
	input wire phase_adjuster_reset_r
);
	// one clock domain, so clocking and reset are given once
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// driving the wire always means pulling it low
	a_ack_drive_low: assert property (sda_oe_r |-> !sda_out_r) else $error("sda driven high");
	// with the clock line parked high the drive never moves
	a_idle_no_drive: assert property (scl_in && $past(scl_in) && $past(scl_in, 2) && $past(scl_in, 3)
		&& $past(scl_in, 4) |-> $stable(sda_oe_r)) else $error("sda drive moved while clock high");
	a_pll_one_cycle: assert property (pll_reset_r |=> !pll_reset_r) else $error("pll pulse too long");
	a_dpa_one_cycle: assert property (phase_adjuster_reset_r |=> !phase_adjuster_reset_r)
		else $error("phase pulse too long");
	// the pulses come while the data byte is being acknowledged
	a_pll_in_ack: assert property (pll_reset_r |-> sda_oe_r) else $error("pll pulse outside ack");
	a_dpa_in_ack: assert property (phase_adjuster_reset_r |-> sda_oe_r)
		else $error("phase pulse outside ack");
	// working copies only move around their reset pulse
	a_pll_work_hold: assert property (!pll_reset_r && !$past(pll_reset_r)
		|-> $stable({loop_work_r, fbd_work_r})) else $error("pll working copy moved");
	a_dpa_work_hold: assert property (!phase_adjuster_reset_r && !$past(phase_adjuster_reset_r)
		|-> $stable(dpa_res_work_r)) else $error("phase working copy moved");
	c_pll: cover property (pll_reset_r);
	c_dpa: cover property (phase_adjuster_reset_r);
	c_ack: cover property ($rose(sda_oe_r));
endmodule // ctp_port_properties
bind ctp_port ctp_port_properties u_props (.clock(clock), .rst(rst), .scl_in(scl_in), .sda_oe_r(sda_oe_r),
	.sda_out_r(sda_out_r), .loop_work_r(loop_work_r), .fbd_work_r(fbd_work_r), .dpa_res_work_r(dpa_res_work_r),
	.pll_reset_r(pll_reset_r), .phase_adjuster_reset_r(phase_adjuster_reset_r));

// [bench/ctp_master.sv]
// bus master model: clock stands high between frames, data is open drain
`timescale 1ns/1ns
module ctp_master
(
	input wire clock,
	input wire sda,
	output reg scl,
	output reg sda_low
);
	// idle bus: both lines released high
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task tick(input integer n);
		repeat (n) @(posedge clock);
	endtask
	// one bit of 8 clocks: data set in the low half, sampled mid high half
	task bitx(input b, output r);
		scl <= 1'b0;
		tick(1);
		sda_low <= !b;
		tick(3);
		scl <= 1'b1;
		tick(2);
		r = sda;
		tick(2);
	endtask
	// s high: start or repeated start; s low: stop
	task frame(input s);
		scl <= 1'b0;
		tick(1);
		sda_low <= !s;
		tick(3);
		scl <= 1'b1;
		tick(4);
		sda_low <= s;
		tick(4);
	endtask
	// eight bits then the acknowledge slot
	task xfer(input [7:0] d, input ab, output [7:0] q, output a);
		integer i;
		for (i = 7; i >= 0; i = i - 1)
			bitx(d[i], q[i]);
		bitx(ab, a);
	endtask
endmodule // ctp_master

// [bench/tb_top.sv]
// self-checking bench for the serial configuration port
`timescale 1ns/1ns
module tb_top;
	reg clock = 1'b0;
	reg rst = 1'b1;
	reg addr_select_pin = 1'b0;
	reg pll_lock = 1'b1;
	integer error_cnt = 0;
	integer samples_checked = 0;
	integer cycles = 0;
	wire scl, sda_low, sda_oe_r, sda_out_r, pll_reset_r, phase_adjuster_reset_r;
	wire sda = !(sda_low | sda_oe_r); // wired low, pull-up otherwise
	wire [7:0] input_ctl_r, loop_work_r, dpa_offset_r, out_en_r, osc_div_r;
	wire [11:0] fbd_work_r;
	wire [1:0] dpa_res_work_r;
	reg [7:0] q;
	reg a;
	localparam [63:0] WDAT = 64'ha515_3402_3c01_5a83; // data for indices 00..07
	always #20 clock = !clock;
	ctp_master m (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));
	ctp_port uut (.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out_r(sda_out_r), .sda_oe_r(sda_oe_r),
		.addr_select_pin(addr_select_pin), .pll_lock(pll_lock), .input_ctl_r(input_ctl_r), .loop_work_r(loop_work_r),
		.fbd_work_r(fbd_work_r), .dpa_offset_r(dpa_offset_r), .dpa_res_work_r(dpa_res_work_r), .out_en_r(out_en_r),
		.osc_div_r(osc_div_r), .pll_reset_r(pll_reset_r), .phase_adjuster_reset_r(phase_adjuster_reset_r));
	task conclude;
		if (error_cnt == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// cut a hang short
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			error_cnt = error_cnt + 1;
			conclude;
		end
	end
	task chk(input string nm, input [11:0] seen, input [11:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// send a byte, compare the acknowledge slot
	task sb(input [7:0] d, input ea);
		m.xfer(d, 1'b1, q, a);
		chk("ack", a, ea);
	endtask
	// read a byte, master answers with ma
	task rb(input [7:0] e, input ma);
		m.xfer(8'hff, ma, q, a);
		chk("rdata", q, e);
	endtask
	// status byte in a transaction of its own, index re-sent
	task rd_stat(input [7:0] e);
		m.frame(1'b1);
		sb(8'h4c, 1'b0);
		sb(8'h12, 1'b0);
		m.frame(1'b1);
		sb(8'h4d, 1'b0);
		rb(e, 1'b1);
	endtask
	// whole map 00..08 in one burst; working copies load on the reset codes
	task t_mwrite;
		integer i;
		chk("fbd_rst", fbd_work_r, 12'hfff);
		m.frame(1'b1);
		sb(8'h4c, 1'b0);
		sb(8'h00, 1'b0);
		for (i = 0; i < 8; i = i + 1)
			sb(WDAT[63 - 8 * i -: 8], 1'b0);
		chk("loop_shadow", loop_work_r, 8'h00);
		chk("res_shadow", dpa_res_work_r, 2'h3);
		sb(8'h5a, 1'b0);
		m.frame(1'b0);
		chk("fbd", fbd_work_r, 12'h234);
		chk("loop", loop_work_r, 8'h15);
		chk("res", dpa_res_work_r, 2'h1);
		chk("osc", osc_div_r, 8'h83);
		chk("in_ctl", input_ctl_r, 8'ha5);
		chk("dpa_os", dpa_offset_r, 8'h3c);
		chk("out_en_w", out_en_r, 8'h5a);
	endtask
	// index write, repeated start, burst read; status with lock low, then high
	task t_read;
		m.frame(1'b1);
		sb(8'h4c, 1'b0);
		sb(8'h01, 1'b0);
		m.frame(1'b1);
		sb(8'h4d, 1'b0);
		rb(8'h15, 1'b0);
		rb(8'h34, 1'b0);
		rb(8'h02, 1'b1);
		pll_lock <= 1'b0;
		rd_stat(8'h00);
		pll_lock <= 1'b1;
		rd_stat(8'h02);
		m.frame(1'b0);
	endtask
	// index 0f plus one lands on 00, not 10
	task t_wrap;
		m.frame(1'b1);
		sb(8'h4c, 1'b0);
		sb(8'h0f, 1'b0);
		sb(8'h77, 1'b0);
		sb(8'h99, 1'b0);
		m.frame(1'b0);
		chk("wrap", input_ctl_r, 8'h99);
	endtask
	// foreign address ignored; pin moves the address pair
	task t_addr;
		m.frame(1'b1);
		sb(8'h4e, 1'b1);
		sb(8'h06, 1'b1);
		m.frame(1'b0);
		addr_select_pin <= 1'b1;
		m.frame(1'b1);
		sb(8'h4c, 1'b1);
		m.frame(1'b1);
		sb(8'h4e, 1'b0);
		sb(8'h06, 1'b0);
		sb(8'h11, 1'b0);
		m.frame(1'b0);
		chk("out_en", out_en_r, 8'h11);
	endtask
	// mid-run reset brings every output register and working copy back
	task t_reset;
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		chk("rst_in_ctl", input_ctl_r, 8'h41);
		chk("rst_out_en", out_en_r, 8'h00);
		chk("rst_osc", osc_div_r, 8'h80);
		chk("rst_dpa_os", dpa_offset_r, 8'h00);
		chk("rst_loop", loop_work_r, 8'h00);
		chk("rst_fbd", fbd_work_r, 12'hfff);
		chk("rst_res", dpa_res_work_r, 2'h3);
	endtask
	initial
	begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		t_mwrite;
		t_read;
		t_wrap;
		t_addr;
		t_reset;
		conclude;
	end
endmodule // tb_top
